// ==== src/hw_monitor_pkg.sv ====
// Shared constants and carrier types for the hardware-monitor register bank.
package hw_monitor_pkg;

  localparam logic [6:0] SCRATCH_LAST  = 7'h1f;
  localparam logic [6:0] VALUE_LO_BASE = 7'h20;
  localparam logic [6:0] VALUE_LO_LAST = 7'h3f;
  localparam logic [6:0] VALUE_HI_BASE = 7'h60;
  localparam logic [6:0] VALUE_HI_LAST = 7'h7f;

  localparam logic [6:0] IDX_CONFIG     = 7'h40;
  localparam logic [6:0] IDX_STATUS_ONE = 7'h41;
  localparam logic [6:0] IDX_STATUS_TWO = 7'h42;
  localparam logic [6:0] IDX_MASK_ONE   = 7'h43;
  localparam logic [6:0] IDX_MASK_TWO   = 7'h44;
  localparam logic [6:0] IDX_CASE_CLEAR = 7'h45;
  localparam logic [6:0] IDX_FAN_DIV    = 7'h47;

  localparam logic [7:0] CONFIG_RESET  = 8'h08;
  localparam logic [7:0] STATUS_RESET  = 8'h00;
  localparam logic [7:0] MASK_RESET    = 8'h00;
  localparam logic [3:0] FAN_DIV_RESET = 4'h5;
  localparam logic [6:0] POINTER_RESET = 7'h00;

  localparam int CFG_SOFT_RESET = 7;
  localparam int CFG_HALT       = 3;
  localparam int CFG_IRQ_ENABLE = 1;
  localparam int CFG_START      = 0;
  localparam int CASE_CLEAR_BIT = 7;
  localparam int MASK_TWO_WIDTH = 6;

  // Value RAM offsets relative to the base of the region.
  localparam logic [4:0] OFS_CORE     = 5'h00;
  localparam logic [4:0] OFS_3V3      = 5'h02;
  localparam logic [4:0] OFS_ANALOG_SUPPLY_INPUT     = 5'h03;
  localparam logic [4:0] OFS_POS12    = 5'h04;
  localparam logic [4:0] OFS_NEG12    = 5'h05;
  localparam logic [4:0] OFS_NEG5     = 5'h06;
  localparam logic [4:0] OFS_TEMP_ONE = 5'h07;
  localparam logic [4:0] OFS_FAN_ONE  = 5'h08;
  localparam logic [4:0] OFS_FAN_TWO  = 5'h09;
  localparam logic [4:0] OFS_FAN_THREE = 5'h0a;

  // Host access strobes, all one-cycle pulses on CLK.
  typedef struct packed {
    logic       addr_wr;
    logic       addr_rd;
    logic       data_wr;
    logic       data_rd;
    logic [7:0] wdata;
  } host_req_s;

  // A finished conversion from the sensing logic.
  typedef struct packed {
    logic       valid;
    logic [4:0] offset;
    logic [7:0] value;
  } sample_s;

endpackage : hw_monitor_pkg

// ==== src/hw_monitor_register_bank.sv ====
// Indexed register bank of the hardware monitor with its limit checking.
`timescale 1ns/100ps
`default_nettype none

module hw_monitor_register_bank (
  input  wire logic                   CLK,
  input  wire logic                   RESET_N,
  input  wire logic                   CE,
  input  wire hw_monitor_pkg::host_req_s HOST,
  output var  logic [7:0]             HOST_RDATA,
  input  wire hw_monitor_pkg::sample_s SAMPLE,
  input  wire logic                   TEMP_TWO_HIGH,
  input  wire logic                   CASE_OPEN_N,
  output var  logic                   SYS_MGMT_IRQ_N,
  output var  logic                   MONITOR_RUN,
  output var  logic [1:0]             FAN_ONE_DIV,
  output var  logic [1:0]             FAN_TWO_DIV
);

  typedef struct packed {
    logic [63:0][7:0]                          ram;
    logic [6:0]                                pointer;
    logic                                      busy;
    logic [7:0]                                config_reg;
    logic [7:0]                                status_one;
    logic [7:0]                                status_two;
    logic [7:0]                                mask_one;
    logic [hw_monitor_pkg::MASK_TWO_WIDTH-1:0] mask_two;
    logic [3:0]                                fan_div;
    logic [7:0]                                rdata;
    logic                                      irq_n;
    logic                                      run;
    logic                                      case_meta;
    logic                                      case_sync;
  } state_s;

  state_s state;
  state_s next_state;

  // Maps a pointer in either RAM region onto the shared array.
  function automatic logic [5:0] ram_slot(input logic [6:0] idx);
    ram_slot = {(idx[6:5] != 2'b00), idx[4:0]};
  endfunction : ram_slot

  function automatic logic in_ram(input logic [6:0] idx);
    in_ram = (idx <= hw_monitor_pkg::VALUE_LO_LAST) || (idx >= hw_monitor_pkg::VALUE_HI_BASE);
  endfunction : in_ram

  always_comb
  begin
    logic [6:0]  ptr;
    logic [5:0]  hi_slot;
    logic [5:0]  lo_slot;
    logic        check_hi;
    logic        check_lo;
    logic [15:0] flag;
    logic [15:0] new_flags;
    logic        out_of_window;
    logic        monitoring;
    logic        pending;
    ptr           = state.pointer;
    hi_slot       = 6'h00;
    lo_slot       = 6'h00;
    check_hi      = 1'b0;
    check_lo      = 1'b0;
    flag          = 16'h0000;
    new_flags     = 16'h0000;
    out_of_window = 1'b0;
    monitoring    = state.config_reg[hw_monitor_pkg::CFG_START] &&
                    !state.config_reg[hw_monitor_pkg::CFG_HALT];
    pending       = |(state.status_one & ~state.mask_one) |
      |(state.status_two[hw_monitor_pkg::MASK_TWO_WIDTH-1:0] & ~state.mask_two);
    next_state    = state;

    // The case input comes from a pin, so it is synchronised first.
    next_state.case_meta = CASE_OPEN_N;
    next_state.case_sync = state.case_meta;

    next_state.run = monitoring;

    // Each reading except fan three has its limits and its status bit; flag is {status_two, status_one}.
    case (SAMPLE.offset)
      hw_monitor_pkg::OFS_CORE:
      begin
        hi_slot  = 6'h2b;
        lo_slot  = 6'h2c;
        check_hi = 1'b1;
        check_lo = 1'b1;
        flag     = 16'h0001;
      end
      hw_monitor_pkg::OFS_3V3:
      begin
        hi_slot  = 6'h2f;
        lo_slot  = 6'h30;
        check_hi = 1'b1;
        check_lo = 1'b1;
        flag     = 16'h0004;
      end
      hw_monitor_pkg::OFS_ANALOG_SUPPLY_INPUT:
      begin
        hi_slot  = 6'h31;
        lo_slot  = 6'h32;
        check_hi = 1'b1;
        check_lo = 1'b1;
        flag     = 16'h0008;
      end
      hw_monitor_pkg::OFS_POS12:
      begin
        hi_slot  = 6'h33;
        lo_slot  = 6'h34;
        check_hi = 1'b1;
        check_lo = 1'b1;
        flag     = 16'h0100;
      end
      hw_monitor_pkg::OFS_NEG12:
      begin
        hi_slot  = 6'h35;
        lo_slot  = 6'h36;
        check_hi = 1'b1;
        check_lo = 1'b1;
        flag     = 16'h0200;
      end
      hw_monitor_pkg::OFS_NEG5:
      begin
        hi_slot  = 6'h37;
        lo_slot  = 6'h38;
        check_hi = 1'b1;
        check_lo = 1'b1;
        flag     = 16'h0400;
      end
      hw_monitor_pkg::OFS_TEMP_ONE:
      begin
        hi_slot  = 6'h39;
        check_hi = 1'b1;
        flag     = 16'h0010;
      end
      hw_monitor_pkg::OFS_FAN_ONE:
      begin
        hi_slot  = 6'h3b;
        check_hi = 1'b1;
        flag     = 16'h0040;
      end
      hw_monitor_pkg::OFS_FAN_TWO:
      begin
        hi_slot  = 6'h3c;
        check_hi = 1'b1;
        flag     = 16'h0080;
      end
      default:
      begin
        check_hi = 1'b0;
      end
    endcase

    // Limits sit in the upper half of the slot array; the RAM holds them at 20h plus offset.
    out_of_window = (check_hi && (SAMPLE.value > state.ram[{1'b1, hi_slot[4:0]}])) ||
                    (check_lo && (SAMPLE.value < state.ram[{1'b1, lo_slot[4:0]}]));

    if (SAMPLE.valid && monitoring)
    begin
      // Fan counts are stored as delivered: clock counts per revolution.
      next_state.ram[{1'b1, SAMPLE.offset}] = SAMPLE.value;
      if (out_of_window)
      begin
        new_flags = flag;
      end
    end
    if (TEMP_TWO_HIGH && monitoring)
    begin
      new_flags[5] = 1'b1;
    end
    if (!state.case_sync)
    begin
      new_flags[12] = 1'b1;
    end

    // Host access: a status read clears it, yet a same-cycle event wins as sets merge last.
    if (HOST.addr_wr)
    begin
      next_state.pointer = HOST.wdata[6:0];
      next_state.busy    = 1'b1;
    end
    else if (HOST.addr_rd)
    begin
      next_state.rdata = {state.busy, state.pointer};
    end
    else if (HOST.data_wr || HOST.data_rd)
    begin
      next_state.busy = 1'b0;
      if (HOST.data_rd && !HOST.data_wr)
      begin
        if (in_ram(ptr))
        begin
          next_state.rdata = state.ram[ram_slot(ptr)];
        end
        else
        begin
          case (ptr)
            hw_monitor_pkg::IDX_CONFIG:
            begin
              next_state.rdata = state.config_reg;
            end
            hw_monitor_pkg::IDX_STATUS_ONE:
            begin
              next_state.rdata      = state.status_one;
              next_state.status_one = 8'h00;
            end
            hw_monitor_pkg::IDX_STATUS_TWO:
            begin
              next_state.rdata      = state.status_two;
              next_state.status_two = 8'h00;
            end
            hw_monitor_pkg::IDX_MASK_ONE:
            begin
              next_state.rdata = state.mask_one;
            end
            hw_monitor_pkg::IDX_MASK_TWO:
            begin
              next_state.rdata = {2'b00, state.mask_two};
            end
            hw_monitor_pkg::IDX_FAN_DIV:
            begin
              next_state.rdata = {state.fan_div, 4'h0};
            end
            default:
            begin
              next_state.rdata = 8'h00;
            end
          endcase
        end
      end
      else
      begin
        if (in_ram(ptr))
        begin
          next_state.ram[ram_slot(ptr)] = HOST.wdata;
        end
        else
        begin
          case (ptr)
            hw_monitor_pkg::IDX_CONFIG:
            begin
              next_state.config_reg = {1'b0, 3'b000, HOST.wdata[3], 1'b0, HOST.wdata[1:0]};
            end
            hw_monitor_pkg::IDX_MASK_ONE:
            begin
              next_state.mask_one = HOST.wdata;
            end
            hw_monitor_pkg::IDX_MASK_TWO:
            begin
              next_state.mask_two = HOST.wdata[hw_monitor_pkg::MASK_TWO_WIDTH-1:0];
            end
            hw_monitor_pkg::IDX_CASE_CLEAR:
            begin
              if (HOST.wdata[hw_monitor_pkg::CASE_CLEAR_BIT])
              begin
                next_state.status_two[4] = 1'b0;
              end
            end
            hw_monitor_pkg::IDX_FAN_DIV:
            begin
              next_state.fan_div = HOST.wdata[7:4];
            end
            default:
            begin
              next_state.rdata = state.rdata;
            end
          endcase
        end
      end

      // Pointer advance after a data-port access below 1Fh, in 60h to 7Eh, or at 41h or 43h.
      if (ptr < hw_monitor_pkg::SCRATCH_LAST)
      begin
        next_state.pointer = ptr + 7'h01;
      end
      else if (ptr >= hw_monitor_pkg::VALUE_HI_BASE && ptr < hw_monitor_pkg::VALUE_HI_LAST)
      begin
        next_state.pointer = ptr + 7'h01;
      end
      else if (ptr == hw_monitor_pkg::IDX_STATUS_ONE || ptr == hw_monitor_pkg::IDX_MASK_ONE)
      begin
        next_state.pointer = ptr + 7'h01;
      end
    end

    next_state.status_one = next_state.status_one | new_flags[7:0] & 8'hfd;
    next_state.status_two = next_state.status_two | new_flags[15:8];

    // Until halt is set, the output stays low while unmasked status pends, even with enable cleared.
    if (state.config_reg[hw_monitor_pkg::CFG_HALT] || !pending)
    begin
      next_state.irq_n = 1'b1;
    end
    else if (state.config_reg[hw_monitor_pkg::CFG_IRQ_ENABLE])
    begin
      next_state.irq_n = 1'b0;
    end
    else
    begin
      next_state.irq_n = state.irq_n;
    end

    // Soft reset restores registers but keeps RAM contents and the host's pointer.
    if (HOST.data_wr && !HOST.addr_wr && !HOST.addr_rd && ptr == hw_monitor_pkg::IDX_CONFIG &&
        HOST.wdata[hw_monitor_pkg::CFG_SOFT_RESET])
    begin
      next_state.config_reg = hw_monitor_pkg::CONFIG_RESET;
      next_state.status_one = hw_monitor_pkg::STATUS_RESET;
      next_state.status_two = hw_monitor_pkg::STATUS_RESET;
      next_state.mask_one   = hw_monitor_pkg::MASK_RESET;
      next_state.mask_two   = '0;
      next_state.fan_div    = hw_monitor_pkg::FAN_DIV_RESET;
      next_state.irq_n      = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state            <= '0;
      state.pointer    <= hw_monitor_pkg::POINTER_RESET;
      state.config_reg <= hw_monitor_pkg::CONFIG_RESET;
      state.status_one <= hw_monitor_pkg::STATUS_RESET;
      state.status_two <= hw_monitor_pkg::STATUS_RESET;
      state.mask_one   <= hw_monitor_pkg::MASK_RESET;
      state.fan_div    <= hw_monitor_pkg::FAN_DIV_RESET;
      state.irq_n      <= 1'b1;
      state.case_meta  <= 1'b1;
      state.case_sync  <= 1'b1;
    end
    else if (CE)
    begin
      state <= next_state;
    end
  end

  assign HOST_RDATA     = state.rdata;
  assign SYS_MGMT_IRQ_N = state.irq_n;
  assign MONITOR_RUN    = state.run;
  assign FAN_ONE_DIV    = state.fan_div[1:0];
  assign FAN_TWO_DIV    = state.fan_div[3:2];
endmodule : hw_monitor_register_bank
`default_nettype wire

// ==== verif/hw_monitor_chk.sv ====
// Port-level assertions for the hardware-monitor register bank.
`timescale 1ns/100ps
`default_nettype none
module hw_monitor_chk (
  input wire logic                      CLK,
  input wire logic                      RESET_N,
  input wire logic                      CE,
  input wire hw_monitor_pkg::host_req_s HOST,
  input wire logic [7:0]                HOST_RDATA,
  input wire logic                      SYS_MGMT_IRQ_N,
  input wire logic                      MONITOR_RUN,
  input wire logic [1:0]                FAN_ONE_DIV,
  input wire logic [1:0]                FAN_TWO_DIV
);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RESET_N);
  sequence s_aw(logic [6:0] a);
    HOST.addr_wr && CE && HOST.wdata[6:0] == a;
  endsequence
  sequence s_cfg;
    s_aw(7'h40) ##2 (HOST.data_wr && CE && !HOST.addr_wr);
  endsequence
  // The pointer readback alone shows a hold at the top of a region.
  property p_hold(logic [6:0] a);
    s_aw(a) ##2 (HOST.data_wr && CE && !HOST.addr_wr) ##2 (HOST.addr_rd && CE && !HOST.addr_wr)
      |=> HOST_RDATA == {1'b0, a};
  endproperty
  rdata_cause_a : assert property (
    $changed(HOST_RDATA) |-> $past((HOST.data_rd || HOST.addr_rd) && CE))
    else $error("Read data changed without a read.");
  fan_div_write_a : assert property (
    $changed({FAN_TWO_DIV, FAN_ONE_DIV}) |-> $past(HOST.data_wr && CE))
    else $error("Fan divisor changed without a write.");
  busy_flag_a : assert property (
    HOST.addr_wr && CE ##2 (HOST.addr_rd && CE && !HOST.addr_wr)
      |=> HOST_RDATA == {1'b1, $past(HOST.wdata[6:0], 3)})
    else $error("Busy or pointer wrong after address write.");
  status_step_a : assert property (
    s_aw(7'h41) ##2 (HOST.data_rd && CE && !HOST.addr_wr) ##2 (HOST.addr_rd && CE && !HOST.addr_wr)
      |=> HOST_RDATA == 8'h42)
    else $error("Pointer did not step to status two.");
  scratch_hold_a : assert property (p_hold(7'h1f))
    else $error("Scratch pointer did not hold.");
  value_hold_a : assert property (p_hold(7'h7f))
    else $error("Value pointer did not hold.");
  soft_reset_a : assert property (
    s_cfg ##0 HOST.wdata[7] |=> ##1 (SYS_MGMT_IRQ_N && !MONITOR_RUN &&
      FAN_ONE_DIV == 2'b01 && FAN_TWO_DIV == 2'b01))
    else $error("Soft reset did not restore outputs.");
  run_follow_a : assert property (
    s_cfg ##0 !HOST.wdata[7]
      |=> ##1 MONITOR_RUN == ($past(HOST.wdata[0], 2) && !$past(HOST.wdata[3], 2)))
    else $error("Run state does not follow the start bit.");
  halt_block_a : assert property (
    s_cfg ##0 (HOST.wdata[3] && !HOST.wdata[7]) |=> ##1 SYS_MGMT_IRQ_N [*3])
    else $error("Interrupt active while halted.");
  zero_keep_a : assert property (
    s_cfg ##0 (HOST.wdata == 8'h00 && !SYS_MGMT_IRQ_N) |=> !SYS_MGMT_IRQ_N [*3])
    else $error("Config write of zero released the interrupt.");
  cover property ($fell(SYS_MGMT_IRQ_N));
  cover property ($rose(MONITOR_RUN));
  cover property (s_cfg ##0 HOST.wdata[7]);
endmodule : hw_monitor_chk
bind hw_monitor_register_bank hw_monitor_chk chk_u (
  .CLK(CLK),
  .RESET_N(RESET_N),
  .CE(CE),
  .HOST(HOST),
  .HOST_RDATA(HOST_RDATA),
  .SYS_MGMT_IRQ_N(SYS_MGMT_IRQ_N),
  .MONITOR_RUN(MONITOR_RUN),
  .FAN_ONE_DIV(FAN_ONE_DIV),
  .FAN_TWO_DIV(FAN_TWO_DIV)
);
`default_nettype wire

// ==== verif/hw_monitor_register_bank_tb.sv ====
// Self-checking bench for the hardware-monitor register bank.
`timescale 1ns/100ps
`default_nettype none
module hw_monitor_register_bank_tb;
  logic                      clk;
  logic                      reset_n;
  logic                      ce;
  hw_monitor_pkg::host_req_s host;
  hw_monitor_pkg::sample_s   sample;
  logic [7:0]                rdata;
  logic                      temp_two;
  logic                      case_n;
  logic                      irq_n;
  logic                      run;
  logic [1:0]                div_one;
  logic [1:0]                div_two;
  int                        fail_count;
  int                        n_compared;
  int                        cycles;
  logic [4:0]  ofs_tab [9] = '{5'h00, 5'h02, 5'h03, 5'h07, 5'h08, 5'h09, 5'h04, 5'h05, 5'h06};
  logic [15:0] exp_tab [9] = '{16'h0100, 16'h0400, 16'h0800, 16'h1000, 16'h4000, 16'h8000,
                               16'h0001, 16'h0002, 16'h0004};
  hw_monitor_register_bank dut_u (
    .CLK(clk),
    .RESET_N(reset_n),
    .CE(ce),
    .HOST(host),
    .HOST_RDATA(rdata),
    .SAMPLE(sample),
    .TEMP_TWO_HIGH(temp_two),
    .CASE_OPEN_N(case_n),
    .SYS_MGMT_IRQ_N(irq_n),
    .MONITOR_RUN(run),
    .FAN_ONE_DIV(div_one),
    .FAN_TWO_DIV(div_two)
  );
  sensor_model sens_u (
    .clk(clk),
    .sample(sample),
    .temp_two_high(temp_two),
    .case_open_n(case_n)
  );
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic final_report();
    if (fail_count == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  // The run takes about 400 cycles, so this ceiling only trips on a hang.
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      final_report();
    end
  end
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  // Kind 0 address write, 1 address read, 2 data write, 3 data read.
  task automatic strobe(input int kind, input logic [7:0] d);
    @(negedge clk);
    host.wdata = d;
    host.addr_wr = kind == 0;
    host.addr_rd = kind == 1;
    host.data_wr = kind == 2;
    host.data_rd = kind == 3;
    @(negedge clk);
    host = '0;
  endtask : strobe
  task automatic rdc(input string name, input logic [7:0] e);
    strobe(3, 8'h00);
    check(name, rdata, e);
  endtask : rdc
  task automatic ard(input logic [7:0] e);
    strobe(1, 8'h00);
    check("addr", rdata, e);
  endtask : ard
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    strobe(0, idx);
    strobe(2, d);
  endtask : wr
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask : gap
  initial
  begin
    host = '0;
    ce = 1'b1;
    reset_n = 1'b0;
    fail_count = 0;
    n_compared = 0;
    cycles = 0;
    gap(20);
    reset_n = 1'b1;
    check("outs", {2'b00, irq_n, run, div_two, div_one}, 8'h25);
    strobe(0, 8'h40);
    rdc("config", 8'h08);
    strobe(0, 8'h41);
    ard(8'hc1);
    ce = 1'b0;
    strobe(0, 8'h05);
    strobe(3, 8'h00);
    ce = 1'b1;
    ard(8'hc1);
    strobe(0, 8'h41);
    rdc("stat1", 8'h00);
    ard(8'h42);
    strobe(0, 8'h1e);
    strobe(2, 8'haa);
    strobe(2, 8'hbb);
    ard(8'h1f);
    strobe(0, 8'h1f);
    strobe(2, 8'hcc);
    ard(8'h1f);
    strobe(0, 8'h1e);
    rdc("scratch", 8'haa);
    rdc("scratch", 8'hcc);
    rdc("scratch", 8'hcc);
    wr(8'h7e, 8'h11);
    strobe(0, 8'h7f);
    strobe(2, 8'h33);
    ard(8'h7f);
    strobe(0, 8'h3e);
    rdc("value", 8'h11);
    ard(8'h3e);
    strobe(0, 8'h3f);
    rdc("value", 8'h33);
    wr(8'h47, 8'hc0);
    gap(2);
    check("divs", {4'h0, div_two, div_one}, 8'h0c);
    strobe(0, 8'h47);
    rdc("fandiv", 8'hc0);
    wr(8'h41, 8'hff);
    strobe(0, 8'h48);
    rdc("unmapped", 8'h00);
    strobe(0, 8'h41);
    rdc("stat1", 8'h00);
    wr(8'h40, 8'h03);
    gap(2);
    check("run", {7'h00, run}, 8'h01);
    for (int i = 0; i < 9; i++)
    begin
      sens_u.emit(ofs_tab[i], 8'h55);
      gap(2);
      check("irq", {7'h00, irq_n}, 8'h00);
      strobe(0, {3'b011, ofs_tab[i]});
      rdc("reading", 8'h55);
      strobe(0, 8'h41);
      rdc("stat1", exp_tab[i][15:8]);
      rdc("stat2", exp_tab[i][7:0]);
      gap(2);
      check("irq", {7'h00, irq_n}, 8'h01);
    end
    wr(8'h6b, 8'h80);
    strobe(2, 8'h10);
    sens_u.emit(5'h00, 8'h55);
    gap(2);
    strobe(0, 8'h41);
    rdc("inwin", 8'h00);
    sens_u.emit(5'h00, 8'h05);
    gap(2);
    strobe(0, 8'h41);
    rdc("below", 8'h01);
    sens_u.pulse_temp_two();
    gap(2);
    strobe(0, 8'h41);
    rdc("stat1", 8'h20);
    wr(8'h43, 8'h01);
    strobe(2, 8'h3f);
    strobe(0, 8'h43);
    rdc("mask1", 8'h01);
    rdc("mask2", 8'h3f);
    sens_u.emit(5'h00, 8'h05);
    gap(3);
    check("irq", {7'h00, irq_n}, 8'h01);
    strobe(0, 8'h41);
    rdc("stat1", 8'h01);
    sens_u.set_case(1'b0);
    gap(5);
    sens_u.set_case(1'b1);
    gap(5);
    strobe(0, 8'h42);
    rdc("stat2", 8'h10);
    sens_u.set_case(1'b0);
    gap(5);
    sens_u.set_case(1'b1);
    gap(5);
    wr(8'h45, 8'h80);
    rdc("caseclr", 8'h00);
    strobe(0, 8'h42);
    rdc("stat2", 8'h00);
    sens_u.emit(5'h02, 8'h55);
    gap(2);
    wr(8'h40, 8'h00);
    gap(3);
    check("irqrun", {6'h00, irq_n, run}, 8'h00);
    wr(8'h40, 8'h80);
    gap(2);
    check("outs", {2'b00, irq_n, run, div_two, div_one}, 8'h25);
    strobe(0, 8'h40);
    rdc("config", 8'h08);
    strobe(0, 8'h43);
    rdc("mask1", 8'h00);
    wr(8'h40, 8'h01);
    sens_u.emit(5'h03, 8'h55);
    gap(3);
    check("irq", {7'h00, irq_n}, 8'h01);
    strobe(0, 8'h41);
    rdc("stat1", 8'h08);
    wr(8'h40, 8'h0b);
    sens_u.emit(5'h02, 8'h55);
    gap(3);
    check("halt", {6'h00, irq_n, run}, 8'h02);
    strobe(0, 8'h41);
    rdc("stat1", 8'h00);
    wr(8'h40, 8'h03);
    gap(2);
    check("run", {7'h00, run}, 8'h01);
    reset_n = 1'b0;
    gap(2);
    reset_n = 1'b1;
    check("outs", {2'b00, irq_n, run, div_two, div_one}, 8'h25);
    ard(8'h00);
    final_report();
  end
endmodule : hw_monitor_register_bank_tb
`default_nettype wire

// ==== verif/sensor_model.sv ====
// Behavioural model of the sensing logic and the chassis switch.
`timescale 1ns/100ps
`default_nettype none
module sensor_model (
  input  wire logic                    clk,
  output var  hw_monitor_pkg::sample_s sample,
  output var  logic                    temp_two_high,
  output var  logic                    case_open_n
);
  initial
  begin
    sample = '0;
    temp_two_high = 1'b0;
    case_open_n = 1'b1;
  end
  // The value bus shows the inverse once idle, so stale data never passes for new.
  task automatic emit(input logic [4:0] ofs, input logic [7:0] val);
    @(negedge clk);
    sample = '{valid: 1'b1, offset: ofs, value: val};
    @(negedge clk);
    sample = '{valid: 1'b0, offset: ofs, value: ~val};
  endtask : emit
  task automatic pulse_temp_two();
    @(negedge clk);
    temp_two_high = 1'b1;
    @(negedge clk);
    temp_two_high = 1'b0;
  endtask : pulse_temp_two
  task automatic set_case(input logic v);
    case_open_n = v;
  endtask : set_case
endmodule : sensor_model
`default_nettype wire
